// [dec_exec.v]
// decoder and executor for the plain decrement and decrement-skip-if-zero instructions
//
// Summary of operation
// - plain decrement is 0000 01da followed by an eight bit file address
// - plain decrement subtracts one; d=0 writes working register, d=1 the byte
// - plain decrement updates carry, half borrow, negative, wrap and zero flags
// - a=0 addresses the access bank; a=1 uses the bank select register
// - extended set, a=0 and f at most 95 use indexed literal offset addressing
// - decrement-skip is 0010 11da followed by an eight bit file address
// - decrement-skip subtracts one and routes the result by the destination bit
// - zero result discards the fetched instruction, runs one nop cycle, flags untouched
// - a discarded two-word instruction costs a second nop cycle
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "dec_exec_regs.vh"
module dec_exec #(
   parameter AW = 12
) (
   input  wire          clk_i,
   input  wire          rst_i,
   // wishbone classic slave
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [7:0]    adr_i,
   input  wire [3:0]    sel_i,
   input  wire [31:0]   dat_i,
   output wire [31:0]   dat_o,
   output wire          ack_o,
   // instruction side
   input  wire          instr_valid_i,
   input  wire [15:0]   instr_i,
   input  wire          next_two_word_i,
   output wire          busy_o,
   output wire          accepted_o,
   output wire          illegal_o,
   output wire          done_o,
   output wire          discard_next_o,
   // data memory side, read data must stand in the cycle the read strobe is high
   output wire [AW-1:0] mem_addr_o,
   output wire          mem_re_o,
   output wire          mem_we_o,
   output wire [7:0]    mem_wdata_o,
   input  wire [7:0]    mem_rdata_i
);

   // -------------------------------------------------------------------------
   // state encoding
   // -------------------------------------------------------------------------
   localparam [5:0] S_IDLE   = 6'h01;
   localparam [5:0] S_DECODE = 6'h02;
   localparam [5:0] S_READ   = 6'h04;
   localparam [5:0] S_CALC   = 6'h08;
   localparam [5:0] S_WRITE  = 6'h10;
   localparam [5:0] S_NOP    = 6'h20;

   reg  [5:0]    state_q;
   reg  [5:0]    state_d;
   reg  [15:0]   instr_q;
   reg  [3:0]    nop_cnt_q;
   reg           double_q;
   reg  [7:0]    operand_q;
   reg  [AW-1:0] mem_addr_q;
   reg           mem_re_q;
   reg           mem_we_q;
   reg  [7:0]    mem_wdata_q;
   reg           done_q;
   reg           illegal_q;
   reg           skip_q;
   reg           discard_q;

   reg           ext_en_q;
   reg  [3:0]    bank_select_reg_q;
   reg  [7:0]    wreg_q;
   reg  [4:0]    status_q;
   reg  [AW-1:0] index_base_q;
   reg           ack_q;
   reg  [31:0]   rdata_q;

   // -------------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------------
   wire [5:0] opc_in            = instr_i[`OPC_HI:`OPC_LO];
   wire       in_decrement_file = (opc_in == `OPC_DECREMENT_FILE_OP);
   wire       in_skip_zero      = (opc_in == `OPC_DECREMENT_SKIP_ZERO_OP);
   wire       take              = instr_valid_i & state_q[0];

   wire [5:0] opc_q                   = instr_q[`OPC_HI:`OPC_LO];
   wire       decrement_skip_zero_op  = (opc_q == `OPC_DECREMENT_SKIP_ZERO_OP);
   wire       decrement_file_op       = ~decrement_skip_zero_op;
   wire       dest_file               = instr_q[`BIT_DEST];
   wire       bank_bit                = instr_q[`BIT_BANK];
   wire [7:0] f_addr                  = instr_q[7:0];

   // -------------------------------------------------------------------------
   // effective address
   // -------------------------------------------------------------------------
   reg [AW-1:0] eff_addr;
   always @* begin
      if (bank_bit) begin
         eff_addr = {bank_select_reg_q, f_addr};
      end else if (ext_en_q && (f_addr <= `INDEXED_MAX_F)) begin
         eff_addr = index_base_q + {{(AW-8){1'b0}}, f_addr};
      end else if (f_addr < `ACCESS_SPLIT) begin
         eff_addr = {{(AW-8){1'b0}}, f_addr};
      end else begin
         eff_addr = {`ACCESS_HI_BANK, f_addr};
      end
   end

   // -------------------------------------------------------------------------
   // arithmetic
   // -------------------------------------------------------------------------
   wire [7:0] alu_result;
   wire       alu_c;
   wire       alu_dc;
   wire       alu_n;
   wire       alu_ov;
   wire       alu_z;

   dec_alu #(
      .WIDTH (8)
   ) u_alu (
      .operand_i                   (operand_q),
      .result_o                    (alu_result),
      .carry_o                     (alu_c),
      .half_borrow_flag_o          (alu_dc),
      .negative_o                  (alu_n),
      .twos_complement_wrap_flag_o (alu_ov),
      .zero_o                      (alu_z)
   );

   // -------------------------------------------------------------------------
   // phase sequencer: decode, read, process, write, then optional nops
   // -------------------------------------------------------------------------
   always @* begin
      case (state_q)
         S_IDLE: begin
            if (take && (in_decrement_file || in_skip_zero)) begin
               state_d = S_DECODE;
            end else begin
               state_d = S_IDLE;
            end
         end
         S_DECODE: state_d = S_READ;
         S_READ:   state_d = S_CALC;
         S_CALC:   state_d = S_WRITE;
         S_WRITE: begin
            if (decrement_skip_zero_op && skip_q) begin
               state_d = S_NOP;
            end else begin
               state_d = S_IDLE;
            end
         end
         S_NOP: begin
            // one nop run covers both skip lengths; its count is loaded in write
            if (nop_cnt_q == 4'h1) begin
               state_d = S_IDLE;
            end else begin
               state_d = S_NOP;
            end
         end
         default:  state_d = S_IDLE;
      endcase
   end

   wire wb_wr = cyc_i & stb_i & we_i & ~ack_q;
   wire wb_rd = cyc_i & stb_i & ~we_i & ~ack_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= S_IDLE;
         instr_q     <= 16'h0000;
         nop_cnt_q   <= 4'h0;
         double_q    <= 1'b0;
         operand_q   <= 8'h00;
         mem_addr_q  <= {AW{1'b0}};
         mem_re_q    <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_wdata_q <= 8'h00;
         done_q      <= 1'b0;
         illegal_q   <= 1'b0;
         skip_q      <= 1'b0;
         discard_q   <= 1'b0;
      end else begin
         state_q   <= state_d;
         mem_re_q  <= 1'b0;
         mem_we_q  <= 1'b0;
         done_q    <= 1'b0;
         illegal_q <= take & ~(in_decrement_file | in_skip_zero);
         discard_q <= 1'b0;
         if (take) begin
            instr_q  <= instr_i;
            skip_q   <= 1'b0;
         end
         if (state_q[1]) begin
            mem_addr_q <= eff_addr;
            mem_re_q   <= 1'b1;
         end
         // no spare phase for a registered memory: the byte must stand while re is high
         if (state_q[2]) begin
            operand_q <= mem_rdata_i;
         end
         if (state_q[3]) begin
            skip_q <= decrement_skip_zero_op & alu_z;
            if (dest_file) begin
               mem_wdata_q <= alu_result;
               mem_we_q    <= 1'b1;
            end
         end
         if (state_q[4]) begin
            if (decrement_skip_zero_op && skip_q) begin
               discard_q <= 1'b1;
               double_q  <= next_two_word_i;
               if (next_two_word_i) begin
                  nop_cnt_q <= {`PHASES_PER_CYC, 1'b0};
               end else begin
                  nop_cnt_q <= {1'b0, `PHASES_PER_CYC};
               end
            end else begin
               done_q   <= 1'b1;
               double_q <= 1'b0;
            end
         end
         if (state_q[5]) begin
            nop_cnt_q <= nop_cnt_q - 4'h1;
            done_q    <= (nop_cnt_q == 4'h1);
         end
      end
   end

   // -------------------------------------------------------------------------
   // software registers; core updates win over a bus write in the same cycle
   // -------------------------------------------------------------------------
   wire core_w_wr  = state_q[3] & ~dest_file;
   wire core_st_wr = state_q[3] & decrement_file_op;

   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_en_q          <= `RST_CTRL;
         bank_select_reg_q <= `RST_BANK;
         wreg_q            <= `RST_WREG;
         status_q          <= `RST_STATUS;
         index_base_q      <= `RST_INDEX_BASE;
      end else begin
         if (wb_wr && sel_i[0]) begin
            case (adr_i)
               `OFS_CTRL:       ext_en_q          <= dat_i[`CTRL_EXT_EN];
               `OFS_BANK:       bank_select_reg_q <= dat_i[3:0];
               `OFS_WREG:       wreg_q            <= dat_i[7:0];
               `OFS_STATUS:     status_q          <= dat_i[4:0];
               `OFS_INDEX_BASE: index_base_q[7:0] <= dat_i[7:0];
               default:         ext_en_q          <= ext_en_q;
            endcase
         end
         if (wb_wr && sel_i[1] && (adr_i == `OFS_INDEX_BASE)) begin
            index_base_q[AW-1:8] <= dat_i[AW-1:8];
         end
         if (core_w_wr) begin
            wreg_q <= alu_result;
         end
         if (core_st_wr) begin
            status_q[`ST_C]  <= alu_c;
            status_q[`ST_DC] <= alu_dc;
            status_q[`ST_Z]  <= alu_z;
            status_q[`ST_OV] <= alu_ov;
            status_q[`ST_N]  <= alu_n;
         end
      end
   end

   // -------------------------------------------------------------------------
   // wishbone read path and acknowledge
   // -------------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= cyc_i & stb_i & ~ack_q;
         if (wb_rd) begin
            case (adr_i)
               `OFS_CTRL:       rdata_q <= {31'h00000000, ext_en_q};
               `OFS_BANK:       rdata_q <= {28'h0000000, bank_select_reg_q};
               `OFS_WREG:       rdata_q <= {24'h000000, wreg_q};
               `OFS_STATUS:     rdata_q <= {27'h0000000, status_q};
               `OFS_INDEX_BASE: rdata_q <= {{(32-AW){1'b0}}, index_base_q};
               `OFS_STATE:      rdata_q <= {28'h0000000, illegal_q, double_q, skip_q,
                                            ~state_q[0]};
               default:         rdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   assign dat_o          = rdata_q;
   assign ack_o          = ack_q;
   assign busy_o         = ~state_q[0];
   assign accepted_o     = take & (in_decrement_file | in_skip_zero);
   assign illegal_o      = illegal_q;
   assign done_o         = done_q;
   assign discard_next_o = discard_q;
   assign mem_addr_o     = mem_addr_q;
   assign mem_re_o       = mem_re_q;
   assign mem_we_o       = mem_we_q;
   assign mem_wdata_o    = mem_wdata_q;

endmodule

// [dec_exec_regs.vh]
// offsets, field positions, encodings and reset values for the decrement execution unit
`ifndef DEC_EXEC_REGS_VH
`define DEC_EXEC_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets on the wishbone slave
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_BANK        8'h04
`define OFS_WREG        8'h08
`define OFS_STATUS      8'h0c
`define OFS_INDEX_BASE  8'h10
`define OFS_STATE       8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_EXT_EN     0
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_OV           3
`define ST_N            4
`define STATE_BUSY      0
`define STATE_SKIP      1
`define STATE_DOUBLE    2
`define STATE_ILLEGAL   3

// ----------------------------------------------------------------------------
// opcode layout: top six bits, then d, then a, then f
// ----------------------------------------------------------------------------
`define OPC_DECREMENT_FILE_OP        6'h01
`define OPC_DECREMENT_SKIP_ZERO_OP      6'h0b
`define OPC_HI          15
`define OPC_LO          10
`define BIT_DEST        9
`define BIT_BANK        8
`define INDEXED_MAX_F   8'h5f
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hf

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RST_CTRL        1'b0
`define RST_BANK        4'h0
`define RST_WREG        8'h00
`define RST_STATUS      5'h00
`define RST_INDEX_BASE  12'h000
`define PHASES_PER_CYC  3'h4

`endif

// [dec_alu.v]
// byte decrement with status flag generation
`timescale 1ns/1ps
module dec_alu #(
   parameter WIDTH = 8
) (
   input  wire [WIDTH-1:0] operand_i,
   output wire [WIDTH-1:0] result_o,
   output wire             carry_o,
   output wire             half_borrow_flag_o,
   output wire             negative_o,
   output wire             twos_complement_wrap_flag_o,
   output wire             zero_o
);
   // carry is the inverted borrow: it drops only when the operand was zero
   assign result_o                    = operand_i - {{(WIDTH-1){1'b0}}, 1'b1};
   assign carry_o                     = |operand_i;
   assign half_borrow_flag_o          = |operand_i[3:0];
   assign negative_o                  = result_o[WIDTH-1];
   assign twos_complement_wrap_flag_o = operand_i[WIDTH-1] & ~result_o[WIDTH-1];
   assign zero_o                      = ~|result_o;
endmodule

// [dec_exec_asserts.sv]
// concurrent checks on the ports of the decrement execution unit
`timescale 1ns/1ps
module dec_exec_asserts #(
   parameter AW = 12
) (
   input wire          clk_i,
   input wire          rst_i,
   input wire          instr_valid_i,
   input wire [15:0]   instr_i,
   input wire          busy_o,
   input wire          accepted_o,
   input wire          illegal_o,
   input wire          done_o,
   input wire          discard_next_o,
   input wire [AW-1:0] mem_addr_o,
   input wire          mem_re_o,
   input wire          mem_we_o,
   input wire [7:0]    mem_wdata_o,
   input wire [7:0]    mem_rdata_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----
   // operand and address seen on the last read
   // ----
   logic [7:0]    op_q;
   logic [AW-1:0] ra_q;
   wire           known_op = instr_i[15:10] == 6'h01 || instr_i[15:10] == 6'h0b;
   always @(posedge clk_i) begin
      if (rst_i) begin
         op_q <= 8'h00;
         ra_q <= '0;
      end else begin
         if (mem_re_o) ra_q <= mem_addr_o;
         if (mem_re_o) op_q <= mem_rdata_i;
      end
   end
   a_decode_match: assert property (instr_valid_i && !busy_o |-> accepted_o == known_op)
      else $error("decode disagrees with opcode");
   a_illegal_flag: assert property (instr_valid_i && !busy_o && !known_op |=> illegal_o && !busy_o)
      else $error("foreign word not flagged");
   a_refuse_busy: assert property (busy_o |-> !accepted_o)
      else $error("accepted while busy");
   a_read_soon: assert property (accepted_o |=> busy_o ##[0:2] mem_re_o)
      else $error("operand read missing");
   a_one_cycle: assert property (accepted_o |-> ##[4:6] (done_o || discard_next_o))
      else $error("instruction cycle too long");
   a_write_value: assert property (mem_we_o |-> mem_wdata_o == op_q - 8'h01 && mem_addr_o == ra_q)
      else $error("written byte not operand minus one");
   a_skip_zero: assert property (discard_next_o |-> op_q == 8'h01)
      else $error("skip without zero result");
   a_skip_len: assert property (discard_next_o |-> ##[3:9] done_o)
      else $error("skip cycle not finished");
   a_done_idle: assert property (done_o |-> !busy_o ##1 !done_o)
      else $error("done not a pulse at idle");
   c_decrement_file_op: cover property (accepted_o && instr_i[15:10] == 6'h01);
   c_skip: cover property (discard_next_o);
   c_illegal: cover property (illegal_o);
   c_write: cover property (mem_we_o);
endmodule

bind dec_exec dec_exec_asserts #(.AW(AW)) dec_exec_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
   .busy_o(busy_o), .accepted_o(accepted_o), .illegal_o(illegal_o), .done_o(done_o),
   .discard_next_o(discard_next_o), .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o),
   .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

// [dec_exec_tb_top.sv]
// self-checking testbench for the decrement execution unit
`timescale 1ns/1ps
`include "dec_exec_regs.vh"
module dec_exec_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00, mem_rdata_i, mem [0:4095], noise_q = 8'h5a;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, q;
   logic        instr_valid_i = 1'b0, next_two_word_i = 1'b0, sk;
   logic [15:0] instr_i = 16'h0000;
   wire  [31:0] dat_o;
   wire         ack_o, busy_o, accepted_o, illegal_o, done_o, discard_next_o, mem_re_o, mem_we_o;
   wire  [11:0] mem_addr_o;
   wire  [7:0]  mem_wdata_o;
   int          fail_count = 0, n_tests = 0, base, n;

   always #20 clk_i = ~clk_i;

   dec_exec #(.AW(12)) dec_exec_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .next_two_word_i(next_two_word_i),
      .busy_o(busy_o), .accepted_o(accepted_o), .illegal_o(illegal_o), .done_o(done_o),
      .discard_next_o(discard_next_o), .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o),
      .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

   // ----
   // data memory; read lines toggle outside the read slot so stale data never passes
   // ----
   assign mem_rdata_i = (mem_re_o === 1'b1) ? mem[mem_addr_o] : noise_q;

   always @(posedge clk_i) begin
      noise_q <= ~noise_q;
      if (mem_we_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
   end

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      // ack and read data are taken at the rising edge that samples ack high
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20) chk("ack", 32'h1, 32'h0);
   endtask

   // offer one word, count cycles from the accepting edge to done
   task automatic run(input logic [15:0] ins, input logic two);
      int k;
      k = 0; n = 0; sk = 1'b0;
      @(posedge clk_i);
      instr_valid_i <= 1'b1; instr_i <= ins; next_two_word_i <= two;
      do begin @(negedge clk_i); k++; end while (accepted_o !== 1'b1 && k < 50);
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      do begin @(negedge clk_i); n++; if (discard_next_o === 1'b1) sk = 1'b1; end
      while (done_o !== 1'b1 && n < 50);
      if (k >= 50 || n >= 50) chk("done timeout", 32'h1, 32'h0);
   endtask

   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0, q);
         chk("reset value", 32'h0, q);
      end
      wb(1'b1, 8'h3c, 32'hff, q);
      wb(1'b0, 8'h3c, 32'h0, q);
      chk("unmapped", 32'h0, q);
   endtask

   task automatic t_decrement_file_op();
      logic [7:0] ini [4] = '{8'h10, 8'h80, 8'h00, 8'h01};
      logic [4:0] st [4] = '{5'h01, 5'h09, 5'h10, 5'h07};
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         mem[12'h020] = ini[i];
         e = ini[i] - 8'h01;
         run(16'h0620, 1'b0);
         base = `PHASES_PER_CYC + 1;
         chk("decrement_file_op byte", e, mem[12'h020]);
         wb(1'b0, `OFS_STATUS, 32'h0, q);
         chk("decrement_file_op status", st[i], q);
         chk("decrement_file_op cycles", base, n);
         chk("decrement_file_op skip", 32'h0, sk);
      end
      mem[12'h021] = 8'h33;
      run(16'h0421, 1'b0);
      wb(1'b0, `OFS_WREG, 32'h0, q);
      chk("decrement_file_op to w", 32'h32, q);
      chk("decrement_file_op byte kept", 32'h33, mem[12'h021]);
   endtask

   task automatic t_addr();
      logic [15:0] ins [7] = '{16'h0745, 16'h0680, 16'h0610, 16'h065f, 16'h0660, 16'h0710, 16'h2e20};
      logic [11:0] ad [7] = '{12'h345, 12'hf80, 12'h210, 12'h25f, 12'hf60, 12'h310, 12'h220};
      wb(1'b1, `OFS_BANK, 32'h3, q);
      wb(1'b1, `OFS_INDEX_BASE, 32'h200, q);
      wb(1'b0, `OFS_BANK, 32'h0, q);
      chk("bank readback", 32'h3, q);
      for (int i = 0; i < 7; i++) begin
         wb(1'b1, `OFS_CTRL, {31'h0, i > 1}, q);
         mem[ad[i]] = 8'h42;
         run(ins[i], 1'b0);
         chk("bank byte", 32'h41, mem[ad[i]]);
      end
   endtask

   task automatic t_skip();
      wb(1'b1, `OFS_CTRL, 32'h0, q);
      wb(1'b1, `OFS_STATUS, 32'h15, q);
      wb(1'b1, `OFS_WREG, 32'h5a, q);
      mem[12'h030] = 8'h05;
      run(16'h2e30, 1'b1);
      chk("dsz byte", 32'h04, mem[12'h030]);
      chk("dsz no skip", 32'h0, sk);
      chk("dsz cycles", base, n);
      mem[12'h030] = 8'h01;
      run(16'h2c30, 1'b0);
      wb(1'b0, `OFS_WREG, 32'h0, q);
      chk("dsz to w", 32'h0, q);
      chk("dsz byte kept", 32'h01, mem[12'h030]);
      chk("dsz skip", 32'h1, sk);
      chk("dsz skip cycles", base + `PHASES_PER_CYC, n);
      run(16'h2e30, 1'b1);
      chk("dsz two word byte", 32'h0, mem[12'h030]);
      chk("dsz two word cycles", base + 2 * `PHASES_PER_CYC, n);
      wb(1'b0, `OFS_STATE, 32'h0, q);
      chk("dsz state", 32'h6, q);
      wb(1'b0, `OFS_STATUS, 32'h0, q);
      chk("dsz status", 32'h15, q);
   endtask

   task automatic t_illegal();
      mem[12'h020] = 8'h09;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= 16'h4e20;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("illegal", 32'h1, illegal_o);
      chk("illegal busy", 32'h0, busy_o);
      repeat (8) @(posedge clk_i);
      chk("illegal byte", 32'h09, mem[12'h020]);
   endtask

   task automatic final_report();
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_decrement_file_op();
      t_addr();
      t_skip();
      t_illegal();
      final_report();
   end

   // the whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      final_report();
   end
endmodule
